// ### shared/watchdog_consts.vh
// Register offsets, field positions, reset values and timing counts of the watchdog block.
`ifndef WATCHDOG_CONSTS_VH
`define WATCHDOG_CONSTS_VH
// Register numbers are word indices; the bus byte address is four times the index.
`define IDX_TIMER_PRESCALE  16'h008E
`define IDX_SECOND_WATCHDOG_CONFIG     16'hA0D8
`define IDX_SECOND_WATCHDOG_TIMEOUT    16'hA0D9
`define OFS_TIMER_PRESCALE  18'h0_0238
`define OFS_SECOND_WATCHDOG_CONFIG     18'h2_8360
`define OFS_SECOND_WATCHDOG_TIMEOUT    18'h2_8364
`define OFS_SECOND_WATCHDOG_COUNT      18'h2_83C0
`define OFS_ACCESS_UNLOCK   18'h2_83C4
`define OFS_IRQ_STATUS      18'h2_83C8
`define OFS_IRQ_MASK        18'h2_83CC
`define OFS_FIRST_WATCHDOG_CONTROL    18'h2_83D0
`define CK_WD1_BIT          7
`define CK_WD0_BIT          6
`define CK_T2_BIT           5
`define CK_T1_BIT           4
`define CK_T0_BIT           3
`define CK_WD2_BIT          2
`define CK_RESET            8'hC4
`define CF_CLEAR_BIT        7
`define CF_RST_EN_BIT       6
`define CF_RST_FLAG_BIT     5
`define CF_IRQ_EN_BIT       4
`define CF_SCALE_LSB        1
`define CF_IRQ_FLAG_BIT     0
`define CF_RESET            8'h00
`define SECOND_WATCHDOG_TIMEOUT_RESET  16'h0FFF
`define UNLOCK_KEY          32'h0000_00AA
`define PRESCALE_FAST       4
`define PRESCALE_SLOW       12
`define SLOW_SCALE_MIN_LOG2 8
`define ST_FIRST_WATCHDOG             0
`define ST_SECOND_WATCHDOG             1
`endif

// ### hdl/dual_watchdog.v
// Dual watchdog with timer prescale flags, reached over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_consts.vh"
module dual_watchdog #(
  parameter FIRST_WATCHDOG_SHIFT_MIN = 17
) (
  input  wire        mclk_i,
  input  wire        reset_n_i,
  input  wire        slow_oscillator_clock_i,
  input  wire [17:0] s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output reg         s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output reg         s_axi_wready_o,
  output reg  [1:0]  s_axi_bresp_o,
  output reg         s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [17:0] s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output reg         s_axi_arready_o,
  output reg  [31:0] s_axi_rdata_o,
  output reg  [1:0]  s_axi_rresp_o,
  output reg         s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  output reg         timer0_tick_o,
  output reg         timer1_tick_o,
  output reg         timer2_tick_o,
  output reg         first_watchdog_timeout_o,
  output reg         system_reset_req_o,
  output reg         wakeup_o,
  output reg         irq_o
);

  // Register state.
  reg  [7:0]  timer_prescale_and_first_watchdog_timeout_r;
  reg         cf_rst_en_r;
  reg         cf_rst_flag_r;
  reg         cf_irq_en_r;
  reg  [2:0]  cf_scale_r;
  reg         cf_irq_flag_r;
  reg  [15:0] second_watchdog_timeout_r;
  reg  [15:0] second_watchdog_count_r;
  reg         unlocked_r;
  reg         first_watchdog_enable_r;
  reg  [1:0]  status_r;
  reg  [1:0]  mask_r;
  reg  [30:0] first_watchdog_count_r;
  reg  [14:0] slow_div_r;
  reg  [3:0]  pre4_r;
  reg  [3:0]  pre12_r;
  reg         slow_s1_r;
  reg         slow_s2_r;
  reg         slow_s3_r;
  reg  [17:0] aw_addr_r;
  reg         aw_have_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         w_have_r;
  reg         second_watchdog_reset_pending_r;

  function [30:0] first_watchdog_limit;
    input [2:0] code;
    begin
      case (code)
        3'd0:    first_watchdog_limit = 31'd1 << FIRST_WATCHDOG_SHIFT_MIN;
        3'd1:    first_watchdog_limit = 31'd1 << (FIRST_WATCHDOG_SHIFT_MIN + 3);
        3'd2:    first_watchdog_limit = 31'd1 << (FIRST_WATCHDOG_SHIFT_MIN + 6);
        3'd3:    first_watchdog_limit = 31'd1 << (FIRST_WATCHDOG_SHIFT_MIN + 9);
        default: first_watchdog_limit = 31'd1 << (FIRST_WATCHDOG_SHIFT_MIN + 10 + {28'd0, code} - 4);
      endcase
    end
  endfunction

  // Only the listed word addresses answer; anything else gets a slave error.
  function addr_mapped;
    input [17:0] addr;
    begin
      case (addr)
        `OFS_TIMER_PRESCALE,
        `OFS_SECOND_WATCHDOG_CONFIG,
        `OFS_SECOND_WATCHDOG_TIMEOUT,
        `OFS_SECOND_WATCHDOG_COUNT,
        `OFS_ACCESS_UNLOCK,
        `OFS_IRQ_STATUS,
        `OFS_IRQ_MASK,
        `OFS_FIRST_WATCHDOG_CONTROL: addr_mapped = 1'b1;
        default:           addr_mapped = 1'b0;
      endcase
    end
  endfunction

  wire [2:0]  wd_code   = {timer_prescale_and_first_watchdog_timeout_r[`CK_WD2_BIT], timer_prescale_and_first_watchdog_timeout_r[`CK_WD1_BIT], timer_prescale_and_first_watchdog_timeout_r[`CK_WD0_BIT]};
  wire [30:0] first_watchdog_lim  = first_watchdog_limit(wd_code);
  wire [7:0]  cf_read   = {1'b0, cf_rst_en_r, cf_rst_flag_r, cf_irq_en_r, cf_scale_r,
                           cf_irq_flag_r};
  wire        slow_rise = slow_s2_r & ~slow_s3_r;
  wire [3:0]  scale_sh  = {1'b0, cf_scale_r} + 4'd`SLOW_SCALE_MIN_LOG2;
  wire [14:0] div_mask  = 15'h7FFF >> (4'd15 - scale_sh);
  // Tick when the low scale bits of the divider all read one before the increment.
  wire        second_watchdog_tick = slow_rise & ((slow_div_r & div_mask) == div_mask);
  wire        second_watchdog_hit  = second_watchdog_tick & (second_watchdog_count_r == second_watchdog_timeout_r);
  // A shorter timeout chosen while the count is already past it expires at once, not after a wrap.
  wire        first_watchdog_hit  = first_watchdog_enable_r & (first_watchdog_count_r >= first_watchdog_lim - 31'd1);

  wire do_write = aw_have_r & w_have_r & ~s_axi_bvalid_o;
  wire wr_cf    = do_write & (aw_addr_r == `OFS_SECOND_WATCHDOG_CONFIG) & w_strb_r[0];
  wire cf_open  = wr_cf & unlocked_r;
  wire clr_cnt  = cf_open & w_data_r[`CF_CLEAR_BIT];
  wire rd_stat  = s_axi_arvalid_i & s_axi_arready_o & (s_axi_araddr_i == `OFS_IRQ_STATUS);

  // The slow oscillator is asynchronous; only its synchronised copy is edge-detected.
  always @(posedge mclk_i) begin
    slow_s1_r <= slow_oscillator_clock_i;
    slow_s2_r <= slow_s1_r;
    slow_s3_r <= slow_s2_r;
  end

  // Timer prescalers: one-cycle enable pulses, no derived clocks.
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pre4_r        <= 4'h0;
      pre12_r       <= 4'h0;
      timer0_tick_o <= 1'b0;
      timer1_tick_o <= 1'b0;
      timer2_tick_o <= 1'b0;
    end else begin
      pre4_r  <= (pre4_r == 4'd`PRESCALE_FAST - 4'd1) ? 4'h0 : pre4_r + 4'd1;
      pre12_r <= (pre12_r == 4'd`PRESCALE_SLOW - 4'd1) ? 4'h0 : pre12_r + 4'd1;
      timer2_tick_o <= timer_prescale_and_first_watchdog_timeout_r[`CK_T2_BIT] ? (pre4_r == 4'h0) : (pre12_r == 4'h0);
      timer1_tick_o <= timer_prescale_and_first_watchdog_timeout_r[`CK_T1_BIT] ? (pre4_r == 4'h0) : (pre12_r == 4'h0);
      timer0_tick_o <= timer_prescale_and_first_watchdog_timeout_r[`CK_T0_BIT] ? (pre4_r == 4'h0) : (pre12_r == 4'h0);
    end
  end

  // Watchdogs. The reset flag survives the block reset so software can see the cause.
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      first_watchdog_count_r   <= 31'd0;
      first_watchdog_timeout_o <= 1'b0;
      slow_div_r     <= 15'd0;
      second_watchdog_count_r   <= 16'd0;
      cf_irq_flag_r  <= 1'b0;
      wakeup_o       <= 1'b0;
      system_reset_req_o <= 1'b0;
      cf_rst_flag_r  <= second_watchdog_reset_pending_r;
      status_r       <= 2'b00;
    end else begin
      first_watchdog_timeout_o <= first_watchdog_hit;
      if (!first_watchdog_enable_r || first_watchdog_hit)
        first_watchdog_count_r <= 31'd0;
      else
        first_watchdog_count_r <= first_watchdog_count_r + 31'd1;
      if (slow_rise)
        slow_div_r <= slow_div_r + 15'd1;
      if (clr_cnt || second_watchdog_hit)
        second_watchdog_count_r <= 16'd0;
      else if (second_watchdog_tick)
        second_watchdog_count_r <= second_watchdog_count_r + 16'd1;
      // Hardware set wins over a software clear in the same cycle.
      if (second_watchdog_hit)
        cf_irq_flag_r <= 1'b1;
      else if (cf_open && !w_data_r[`CF_IRQ_FLAG_BIT])
        cf_irq_flag_r <= 1'b0;
      if (cf_open && !w_data_r[`CF_RST_FLAG_BIT])
        cf_rst_flag_r <= 1'b0;
      wakeup_o <= second_watchdog_hit & cf_irq_en_r;
      system_reset_req_o <= second_watchdog_hit & cf_rst_en_r;
      status_r[`ST_FIRST_WATCHDOG] <= first_watchdog_hit | (status_r[`ST_FIRST_WATCHDOG] & ~rd_stat);
      status_r[`ST_SECOND_WATCHDOG] <= (second_watchdog_hit & cf_irq_en_r) | (status_r[`ST_SECOND_WATCHDOG] & ~rd_stat);
    end
  end

  // A reset-cause latch that the block reset does not clear.
  always @(posedge mclk_i) begin
    if (second_watchdog_hit && cf_rst_en_r)
      second_watchdog_reset_pending_r <= 1'b1;
    else if (reset_n_i && cf_open && !w_data_r[`CF_RST_FLAG_BIT])
      second_watchdog_reset_pending_r <= 1'b0;
    else if (second_watchdog_reset_pending_r !== 1'b1)
      second_watchdog_reset_pending_r <= 1'b0;
  end

  always @(posedge mclk_i) begin
    if (!reset_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(status_r & mask_r) | (cf_irq_flag_r & cf_irq_en_r);
  end

  // AXI4-Lite write path: address and data are taken in either order.
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 18'h0_0000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= 2'b00;
      timer_prescale_and_first_watchdog_timeout_r <= `CK_RESET;
      cf_rst_en_r <= 1'b0;
      cf_irq_en_r <= 1'b0;
      cf_scale_r <= 3'b000;
      second_watchdog_timeout_r <= `SECOND_WATCHDOG_TIMEOUT_RESET;
      unlocked_r <= 1'b0;
      first_watchdog_enable_r <= 1'b1;
      mask_r <= 2'b00;
    end else begin
      s_axi_awready_o <= ~aw_have_r & ~s_axi_awready_o & s_axi_awvalid_i;
      s_axi_wready_o <= ~w_have_r & ~s_axi_wready_o & s_axi_wvalid_i;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end
      if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= addr_mapped(aw_addr_r) ? 2'b00 : 2'b10;
        // Any write other than the unlock key relocks protected registers.
        unlocked_r <= (aw_addr_r == `OFS_ACCESS_UNLOCK) && (w_data_r == `UNLOCK_KEY);
        if (w_strb_r[0]) begin
          case (aw_addr_r)
            `OFS_TIMER_PRESCALE: timer_prescale_and_first_watchdog_timeout_r <= w_data_r[7:0];
            `OFS_SECOND_WATCHDOG_CONFIG: begin
              if (unlocked_r) begin
                cf_rst_en_r <= w_data_r[`CF_RST_EN_BIT];
                cf_irq_en_r <= w_data_r[`CF_IRQ_EN_BIT];
                cf_scale_r <= w_data_r[`CF_SCALE_LSB+2:`CF_SCALE_LSB];
              end
            end
            `OFS_SECOND_WATCHDOG_TIMEOUT: if (unlocked_r) second_watchdog_timeout_r[7:0] <= w_data_r[7:0];
            `OFS_IRQ_MASK: mask_r <= w_data_r[1:0];
            `OFS_FIRST_WATCHDOG_CONTROL: first_watchdog_enable_r <= w_data_r[0];
            default: mask_r <= mask_r;
          endcase
        end
        if (w_strb_r[1] && aw_addr_r == `OFS_SECOND_WATCHDOG_TIMEOUT && unlocked_r)
          second_watchdog_timeout_r[15:8] <= w_data_r[15:8];
      end
    end
  end

  // AXI4-Lite read path: one cycle to accept, data on the next.
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= 2'b00;
    end else begin
      s_axi_arready_o <= ~s_axi_rvalid_o & ~s_axi_arready_o & s_axi_arvalid_i;
      if (s_axi_rvalid_o && s_axi_rready_i)
        s_axi_rvalid_o <= 1'b0;
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= addr_mapped(s_axi_araddr_i) ? 2'b00 : 2'b10;
        case (s_axi_araddr_i)
          `OFS_TIMER_PRESCALE: s_axi_rdata_o <= {24'h00_0000, timer_prescale_and_first_watchdog_timeout_r[7:2], 2'b00};
          `OFS_SECOND_WATCHDOG_CONFIG:    s_axi_rdata_o <= {24'h00_0000, cf_read};
          `OFS_SECOND_WATCHDOG_TIMEOUT:   s_axi_rdata_o <= {16'h0000, second_watchdog_timeout_r};
          `OFS_SECOND_WATCHDOG_COUNT:     s_axi_rdata_o <= {16'h0000, second_watchdog_count_r};
          `OFS_ACCESS_UNLOCK:  s_axi_rdata_o <= {31'd0, unlocked_r};
          `OFS_IRQ_STATUS:     s_axi_rdata_o <= {30'd0, status_r};
          `OFS_IRQ_MASK:       s_axi_rdata_o <= {30'd0, mask_r};
          `OFS_FIRST_WATCHDOG_CONTROL:   s_axi_rdata_o <= {31'd0, first_watchdog_enable_r};
          default: begin
            s_axi_rdata_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ### verification/dual_watchdog_sva.sv
// Port-level concurrent checks for the dual watchdog.
`timescale 1ns/100ps
`default_nettype none
module dual_watchdog_sva #(
  parameter FIRST_WATCHDOG_SHIFT_MIN = 17
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic timer0_tick_o,
  input wire logic timer1_tick_o,
  input wire logic timer2_tick_o,
  input wire logic first_watchdog_timeout_o,
  input wire logic system_reset_req_o,
  input wire logic wakeup_o,
  input wire logic irq_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // Whatever the prescale flag, no divider is faster than four clocks.
  property p_t0_gap; timer0_tick_o |=> !timer0_tick_o [*3]; endproperty
  a_t0_gap: assert property (p_t0_gap) else $error("timer0 ticks too close");
  property p_t1_gap; timer1_tick_o |=> !timer1_tick_o [*3]; endproperty
  a_t1_gap: assert property (p_t1_gap) else $error("timer1 ticks too close");
  property p_t2_gap; timer2_tick_o |=> !timer2_tick_o [*3]; endproperty
  a_t2_gap: assert property (p_t2_gap) else $error("timer2 ticks too close");
  property p_wd1_pulse; first_watchdog_timeout_o |=> !first_watchdog_timeout_o; endproperty
  a_wd1_pulse: assert property (p_wd1_pulse) else $error("timeout pulse too long");
  property p_rst_pulse; $rose(system_reset_req_o) |=> $fell(system_reset_req_o); endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
  // The interrupt line follows a wake pulse after its one-cycle register lag.
  property p_wake_irq; wakeup_o |-> ##[1:2] irq_o; endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake without interrupt");
  property p_one_b; s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o; endproperty
  a_one_b: assert property (p_one_b) else $error("write response repeated");
  property p_one_r; s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o; endproperty
  a_one_r: assert property (p_one_r) else $error("read data repeated");
endmodule
`default_nettype wire

// ### verification/test_dual_watchdog.sv
// Self-checking bench for the dual watchdog block.
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_consts.vh"
module test_dual_watchdog;
  localparam int SHIFT = 1;
  localparam int BOUND = 40000;
  logic        mclk_i = 0;
  logic        reset_n_i = 0;
  logic        slow_clk = 0;
  logic [17:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire         awready, wready, bvalid, arready, rvalid, irq, wake, sysrst, wd1;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [2:0]  tick;
  wire  [5:0]  ev = {sysrst, wake, wd1, tick};
  int          bad_count = 0, checks = 0, wake_cnt = 0, c;
  int          tab [8] = '{0, 3, 6, 9, 10, 11, 12, 13};
  dual_watchdog #(.FIRST_WATCHDOG_SHIFT_MIN(SHIFT)) dual_watchdog_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .slow_oscillator_clock_i(slow_clk),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .timer0_tick_o(tick[0]),
    .timer1_tick_o(tick[1]), .timer2_tick_o(tick[2]), .first_watchdog_timeout_o(wd1),
    .system_reset_req_o(sysrst), .wakeup_o(wake), .irq_o(irq));
  always #20 mclk_i = ~mclk_i;
  // The slow clock is short and out of phase with the bus clock to keep the run brief.
  always #173 slow_clk = ~slow_clk;
  always @(posedge mclk_i) if (wake) wake_cnt++;
  function automatic logic [31:0] ckv(input logic [2:0] code, input logic [2:0] t);
    ckv = {24'h00_0000, code[1], code[0], t, code[2], 2'b00};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    $display("mismatch at %0t: wait ran out", $time);
    close_out();
  endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] eb = 2'b00);
    int n;
    n = 0;
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (n >= 50) hang();
    chk({30'h0, bresp}, {30'h0, eb});
  endtask
  task automatic uw(input logic [17:0] a, input logic [31:0] d);
    wr(`OFS_ACCESS_UNLOCK, `UNLOCK_KEY);
    wr(a, d);
  endtask
  task automatic rdc(input logic [17:0] a, input logic [31:0] exp, input logic [1:0] er,
                     input logic [31:0] m = 32'hFFFF_FFFF);
    int n;
    n = 0;
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (n >= 50) hang();
    chk(rdata & m, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic hit(input int i, output int n);
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (!ev[i] && n < BOUND);
    if (n >= BOUND) hang();
  endtask
  task automatic gap(input int i, input int exp);
    hit(i, c);
    hit(i, c);
    chk(c, exp);
  endtask
  initial begin
    int v, r, code;
    v = $urandom(39);
    r = $urandom % 8;
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rdc(`OFS_TIMER_PRESCALE, ckv(3'h7, 3'h0), 2'b00);
    rdc(`OFS_SECOND_WATCHDOG_CONFIG, 32'h0000_0000, 2'b00);
    rdc(18'h0_0020, 32'h0000_0000, 2'b10);
    wr(18'h0_0020, 32'h0000_0000, 2'b10);
    for (int i = 0; i < 3; i++) gap(i, 12);
    uw(`OFS_TIMER_PRESCALE, ckv(3'h7, 3'h7));
    for (int i = 0; i < 3; i++) gap(i, 4);
    // Every timeout code is visited once, in an order scrambled by the seed.
    for (int k = 0; k < 8; k++) begin
      code = k ^ r;
      uw(`OFS_TIMER_PRESCALE, ckv(code[2:0], 3'h0));
      rdc(`OFS_TIMER_PRESCALE, ckv(code[2:0], 3'h0), 2'b00);
      gap(3, 1 << (SHIFT + tab[code]));
    end
    uw(`OFS_SECOND_WATCHDOG_TIMEOUT, 1 + $urandom % 2);
    uw(`OFS_IRQ_MASK, 32'h0000_0002);
    wr(`OFS_SECOND_WATCHDOG_CONFIG, 32'h0000_0010);
    rdc(`OFS_SECOND_WATCHDOG_CONFIG, 32'h0000_0000, 2'b00);
    uw(`OFS_SECOND_WATCHDOG_CONFIG, 32'h0000_0090);
    rdc(`OFS_SECOND_WATCHDOG_CONFIG, 32'h0000_0010, 2'b00);
    hit(4, c);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h0000_0001);
    rdc(`OFS_IRQ_STATUS, 32'h0000_0002, 2'b00, 32'h0000_0002);
    rdc(`OFS_SECOND_WATCHDOG_CONFIG, 32'h0000_0011, 2'b00);
    rdc(`OFS_IRQ_STATUS, 32'h0000_0000, 2'b00, 32'h0000_0002);
    uw(`OFS_SECOND_WATCHDOG_CONFIG, 32'h0000_0010);
    rdc(`OFS_SECOND_WATCHDOG_CONFIG, 32'h0000_0010, 2'b00);
    chk({31'h0, irq}, 32'h0000_0000);
    uw(`OFS_IRQ_MASK, 32'h0000_0000);
    v = wake_cnt;
    uw(`OFS_SECOND_WATCHDOG_CONFIG, 32'h0000_00C0);
    hit(5, c);
    chk(wake_cnt, v);
    chk({31'h0, irq}, 32'h0000_0000);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rdc(`OFS_SECOND_WATCHDOG_CONFIG, 32'h0000_0020, 2'b00);
    uw(`OFS_SECOND_WATCHDOG_CONFIG, 32'h0000_0000);
    rdc(`OFS_SECOND_WATCHDOG_CONFIG, 32'h0000_0000, 2'b00);
    close_out();
  end
endmodule
bind dual_watchdog dual_watchdog_sva #(.FIRST_WATCHDOG_SHIFT_MIN(FIRST_WATCHDOG_SHIFT_MIN)) dual_watchdog_sva_inst (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .timer0_tick_o(timer0_tick_o),
  .timer1_tick_o(timer1_tick_o), .timer2_tick_o(timer2_tick_o),
  .first_watchdog_timeout_o(first_watchdog_timeout_o), .system_reset_req_o(system_reset_req_o),
  .wakeup_o(wakeup_o), .irq_o(irq_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i));
`default_nettype wire
